/* design/lcl_command_legality.sv */
`timescale 1ns/1ps
module lcl_command_legality (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       ck,
  input  wire logic       cke,
  input  wire logic       cs_n,
  input  wire logic       ras_n,
  input  wire logic       cas_n,
  input  wire logic       we_n,
  input  wire logic [1:0] ba,
  input  wire logic       a10,
  output logic            cmd_seen,
  output logic            cmd_accepted,
  output logic            cmd_ignored,
  output logic            cmd_illegal,
  output logic [2:0]      cmd_code,
  output logic [2:0]      dev_state,
  output logic [3:0]      bank_idle,
  output logic            all_idle
);

  typedef struct packed {
    logic [lcl_pkg::PIN_W-1:0] s1;
    logic [lcl_pkg::PIN_W-1:0] s2;
    logic                      ck_prev;
    logic                      cke_prev;
    lcl_pkg::lcl_dev_e         dev;
    logic [7:0]                tmr;
    logic                      seen;
    logic                      acc;
    logic                      ign;
    logic                      ill;
    lcl_pkg::lcl_cmd_e         code;
  } lcl_ctl_s;

  lcl_ctl_s          q;
  lcl_ctl_s          d;
  lcl_bank_if        bus ();
  logic              rise;
  logic              cke_now;
  logic              idle_all;
  logic              bank_cmd;
  lcl_pkg::lcl_cmd_e cmd;

  genvar gi;
  generate
    for (gi = 0; gi < lcl_pkg::NUM_BANKS; gi++)
    begin : g_bank
      lcl_bank #(.IDX(gi)) u_bank (
        .clk  (clk),
        .rstn (rstn),
        .bus  (bus.bank)
      );
    end
  endgenerate

  always_comb
  begin
    d      = q;
    d.s1   = {ck, cke, cs_n, ras_n, cas_n, we_n, ba, a10};
    d.s2   = q.s1;
    d.ck_prev = q.s2[lcl_pkg::PIN_CK];
    d.seen = 1'b0;
    d.acc  = 1'b0;
    d.ign  = 1'b0;
    d.ill  = 1'b0;
    // link clock passes two sample stages (s1, s2), so a rising edge is seen two clk late
    rise     = q.s2[lcl_pkg::PIN_CK] && !q.ck_prev;
    cke_now  = q.s2[lcl_pkg::PIN_CKE];
    cmd      = lcl_pkg::decode_cmd(q.s2[lcl_pkg::PIN_CS],
                                   q.s2[lcl_pkg::PIN_RAS],
                                   q.s2[lcl_pkg::PIN_CAS],
                                   q.s2[lcl_pkg::PIN_WE]);
    idle_all = &bus.idle;
    bank_cmd = cmd inside {lcl_pkg::CMD_BST, lcl_pkg::CMD_READ,
                           lcl_pkg::CMD_WRITE, lcl_pkg::CMD_ACT,
                           lcl_pkg::CMD_PRE};
    bus.cmd      = cmd;
    bus.ba       = q.s2[lcl_pkg::PIN_BA +: 2];
    bus.auto_pre = q.s2[lcl_pkg::PIN_A10];
    bus.stb      = 1'b0;

    if (q.tmr != 8'h00)
      d.tmr = q.tmr - 8'h01;
    if (q.dev inside {lcl_pkg::DEV_REFRESH, lcl_pkg::DEV_MODE_SET,
                      lcl_pkg::DEV_SR_EXIT, lcl_pkg::DEV_PD_EXIT}
        && q.tmr <= 8'h01)
      d.dev = lcl_pkg::DEV_NORMAL;

    if (rise)
    begin
      d.seen     = 1'b1;
      d.code     = cmd;
      d.cke_prev = cke_now;
      unique case (q.dev)
        lcl_pkg::DEV_NORMAL, lcl_pkg::DEV_POWER_DOWN:
        begin
          if (!q.cke_prev || q.dev == lcl_pkg::DEV_POWER_DOWN)
          begin
            // enable low before: power-down handling
            if (cke_now)
            begin
              d.dev = lcl_pkg::DEV_PD_EXIT;
              d.tmr = lcl_pkg::PDEX_CYC;
              d.acc = 1'b1;
            end
            else
            begin
              d.dev = lcl_pkg::DEV_POWER_DOWN;
              d.ign = 1'b1;
            end
          end
          else if (!cke_now)
          begin
            // enable falling: only nop or refresh, only all idle
            if (idle_all && cmd == lcl_pkg::CMD_REF)
            begin
              d.dev = lcl_pkg::DEV_SELF_REFRESH;
              d.acc = 1'b1;
            end
            else if (idle_all && cmd == lcl_pkg::CMD_NOP)
            begin
              d.dev = lcl_pkg::DEV_POWER_DOWN;
              d.acc = 1'b1;
            end
            else
              d.ill = 1'b1;
          end
          else if (cmd == lcl_pkg::CMD_NOP)
            d.ign = 1'b1;
          else if (cmd == lcl_pkg::CMD_REF ||
                   cmd == lcl_pkg::CMD_MRS)
          begin
            if (idle_all)
            begin
              d.dev = (cmd == lcl_pkg::CMD_REF) ? lcl_pkg::DEV_REFRESH
                                                : lcl_pkg::DEV_MODE_SET;
              d.tmr = (cmd == lcl_pkg::CMD_REF) ? lcl_pkg::RFC_CYC
                                                : lcl_pkg::MRD_CYC;
              d.acc = 1'b1;
            end
            else
              d.ill = 1'b1;
          end
          else if (bank_cmd)
          begin
            // one bad bank spoils a precharge-all
            if (|bus.illegal)
              d.ill = 1'b1;
            else
            begin
              bus.stb = 1'b1;
              d.acc   = |bus.take;
              d.ign   = !(|bus.take);
            end
          end
        end
        lcl_pkg::DEV_SELF_REFRESH:
        begin
          if (!cke_now)
            d.ign = 1'b1;
          else if (cmd == lcl_pkg::CMD_NOP)
          begin
            d.dev = lcl_pkg::DEV_SR_EXIT;
            d.tmr = lcl_pkg::XSR_CYC;
            d.acc = 1'b1;
          end
          else
            d.ill = 1'b1;
        end
        lcl_pkg::DEV_REFRESH, lcl_pkg::DEV_MODE_SET,
        lcl_pkg::DEV_SR_EXIT:
        begin
          // exit setup window is checked like a busy refresh
          d.ign = (cmd == lcl_pkg::CMD_NOP);
          d.ill = (cmd != lcl_pkg::CMD_NOP);
        end
        lcl_pkg::DEV_PD_EXIT:
          d.ign = 1'b1;
        default:
          d.dev = lcl_pkg::DEV_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q.s1       <= lcl_pkg::PIN_RST;
      q.s2       <= lcl_pkg::PIN_RST;
      q.ck_prev  <= 1'b0;
      q.cke_prev <= lcl_pkg::CKE_RST;
      q.dev      <= lcl_pkg::DEV_NORMAL;
      q.tmr      <= lcl_pkg::TMR_RST;
      q.seen     <= 1'b0;
      q.acc      <= 1'b0;
      q.ign      <= 1'b0;
      q.ill      <= 1'b0;
      q.code     <= lcl_pkg::CMD_NOP;
    end
    else
      q <= d;
  end

  assign cmd_seen     = q.seen;
  assign cmd_accepted = q.acc;
  assign cmd_ignored  = q.ign;
  assign cmd_illegal  = q.ill;
  assign cmd_code     = q.code;
  assign dev_state    = q.dev;
  assign bank_idle    = bus.idle;
  assign all_idle     = &bus.idle;

endmodule : lcl_command_legality

/* design/lcl_pkg.sv */
package lcl_pkg;

  localparam int NUM_BANKS = 4;
  localparam int CLK_MHZ   = 100;

  // minimum timings in ns, converted to whole clk cycles rounded up
  localparam int T_RP_NS   = 18;
  localparam int T_RCD_NS  = 18;
  localparam int T_WR_NS   = 15;
  localparam int T_RDAP_NS = 40;
  localparam int T_RFC_NS  = 72;
  localparam int T_MRD_NS  = 12;
  localparam int T_PDEX_NS = 10;
  localparam int T_XSR_NS  = 120;

  localparam logic [7:0] RP_CYC   = 8'((T_RP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RCD_CYC  = 8'((T_RCD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] WR_CYC   = 8'((T_WR_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RDAP_CYC = 8'((T_RDAP_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] RFC_CYC  = 8'((T_RFC_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] MRD_CYC  = 8'((T_MRD_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] PDEX_CYC = 8'((T_PDEX_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] XSR_CYC  = 8'((T_XSR_NS * CLK_MHZ + 999) / 1000);

  // bit positions inside the synchronised pin vector
  localparam int PIN_CK   = 8;
  localparam int PIN_CKE  = 7;
  localparam int PIN_CS   = 6;
  localparam int PIN_RAS  = 5;
  localparam int PIN_CAS  = 4;
  localparam int PIN_WE   = 3;
  localparam int PIN_BA   = 1;
  localparam int PIN_A10  = 0;
  localparam int PIN_W    = 9;

  localparam logic [PIN_W-1:0] PIN_RST     = 9'h000;
  localparam logic             CKE_RST     = 1'b0;
  localparam logic [7:0]       TMR_RST     = 8'h00;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_BST, CMD_READ, CMD_WRITE,
    CMD_ACT, CMD_PRE, CMD_REF, CMD_MRS
  } lcl_cmd_e;

  typedef enum logic [2:0] {
    BK_IDLE, BK_ACTIVATING, BK_ACTIVE, BK_WR_RECOVER,
    BK_READ_AP, BK_WRITE_AP, BK_PRECHARGING
  } lcl_bank_e;

  typedef enum logic [2:0] {
    DEV_NORMAL, DEV_REFRESH, DEV_MODE_SET, DEV_SELF_REFRESH,
    DEV_SR_EXIT, DEV_POWER_DOWN, DEV_PD_EXIT
  } lcl_dev_e;

  function automatic lcl_cmd_e decode_cmd(input logic cs_n,
                                          input logic ras_n,
                                          input logic cas_n,
                                          input logic we_n);
    lcl_cmd_e c;
    c = CMD_NOP;
    if (!cs_n)
    begin
      unique case ({ras_n, cas_n, we_n})
        3'h7: c = CMD_NOP;
        3'h6: c = CMD_BST;
        3'h5: c = CMD_READ;
        3'h4: c = CMD_WRITE;
        3'h3: c = CMD_ACT;
        3'h2: c = CMD_PRE;
        3'h1: c = CMD_REF;
        3'h0: c = CMD_MRS;
      endcase
    end
    return c;
  endfunction : decode_cmd

endpackage : lcl_pkg

/* design/lcl_bank_if.sv */
`timescale 1ns/1ps
interface lcl_bank_if;
  logic                stb;
  lcl_pkg::lcl_cmd_e   cmd;
  logic                auto_pre;
  logic [1:0]          ba;
  wire  [3:0]          illegal;
  wire  [3:0]          nop;
  wire  [3:0]          take;
  wire  [3:0]          idle;

  modport ctl  (output stb, cmd, auto_pre, ba,
                input  illegal, nop, take, idle);
  modport bank (input  stb, cmd, auto_pre, ba,
                output illegal, nop, take, idle);
endinterface : lcl_bank_if

/* design/lcl_bank.sv */
`timescale 1ns/1ps
module lcl_bank #(
  parameter int IDX = 0
) (
  input wire logic clk,
  input wire logic rstn,
  lcl_bank_if.bank bus
);

  typedef struct packed {
    lcl_pkg::lcl_bank_e st;
    logic [7:0]         tmr;
  } lcl_bank_s;

  lcl_bank_s q;
  lcl_bank_s d;
  logic      sel;
  logic      bcmd;
  logic      ill;
  logic      nopc;
  logic      go;

  always_comb
  begin
    d    = q;
    ill  = 1'b0;
    nopc = 1'b0;
    // precharge-all selects every bank regardless of ba
    sel  = (bus.ba == 2'(IDX)) ||
           (bus.cmd == lcl_pkg::CMD_PRE && bus.auto_pre);
    bcmd = bus.cmd inside {lcl_pkg::CMD_BST, lcl_pkg::CMD_READ,
                           lcl_pkg::CMD_WRITE, lcl_pkg::CMD_ACT,
                           lcl_pkg::CMD_PRE};
    if (q.tmr != 8'h00)
      d.tmr = q.tmr - 8'h01;
    unique case (q.st)
      lcl_pkg::BK_IDLE:
      begin
        nopc = (bus.cmd == lcl_pkg::CMD_PRE);
        ill  = (bus.cmd != lcl_pkg::CMD_ACT) && !nopc;
      end
      lcl_pkg::BK_ACTIVE:
        ill = (bus.cmd == lcl_pkg::CMD_ACT);
      lcl_pkg::BK_WR_RECOVER:
        ill = (bus.cmd != lcl_pkg::CMD_WRITE);
      lcl_pkg::BK_PRECHARGING:
      begin
        nopc = (bus.cmd == lcl_pkg::CMD_PRE);
        ill  = !nopc;
      end
      default:
        ill = 1'b1;
    endcase
    go = bus.stb && sel && bcmd && !ill && !nopc;
    unique case (q.st)
      lcl_pkg::BK_IDLE:
        if (go)
        begin
          d.st  = lcl_pkg::BK_ACTIVATING;
          d.tmr = lcl_pkg::RCD_CYC;
        end
      lcl_pkg::BK_ACTIVATING:
        if (q.tmr <= 8'h01)
          d.st = lcl_pkg::BK_ACTIVE;
      lcl_pkg::BK_ACTIVE, lcl_pkg::BK_WR_RECOVER:
      begin
        if (q.st == lcl_pkg::BK_WR_RECOVER && q.tmr <= 8'h01)
          d.st = lcl_pkg::BK_ACTIVE;
        if (go && bus.cmd == lcl_pkg::CMD_WRITE)
        begin
          d.st  = bus.auto_pre ? lcl_pkg::BK_WRITE_AP
                               : lcl_pkg::BK_WR_RECOVER;
          d.tmr = lcl_pkg::WR_CYC;
        end
        else if (go && bus.cmd == lcl_pkg::CMD_READ && bus.auto_pre)
        begin
          d.st  = lcl_pkg::BK_READ_AP;
          d.tmr = lcl_pkg::RDAP_CYC;
        end
        else if (go && bus.cmd == lcl_pkg::CMD_PRE)
        begin
          d.st  = lcl_pkg::BK_PRECHARGING;
          d.tmr = lcl_pkg::RP_CYC;
        end
      end
      lcl_pkg::BK_READ_AP, lcl_pkg::BK_WRITE_AP:
        if (q.tmr <= 8'h01)
        begin
          d.st  = lcl_pkg::BK_PRECHARGING;
          d.tmr = lcl_pkg::RP_CYC;
        end
      lcl_pkg::BK_PRECHARGING:
        if (q.tmr <= 8'h01)
          d.st = lcl_pkg::BK_IDLE;
      default:
        d.st = lcl_pkg::BK_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      q.st  <= lcl_pkg::BK_IDLE;
      q.tmr <= lcl_pkg::TMR_RST;
    end
    else
      q <= d;
  end

  assign bus.illegal[IDX] = sel && bcmd && ill;
  assign bus.nop[IDX]     = sel && bcmd && nopc;
  assign bus.take[IDX]    = sel && bcmd && !ill && !nopc;
  assign bus.idle[IDX]    = (q.st == lcl_pkg::BK_IDLE);

endmodule : lcl_bank

/* verification/lcl_ctrl_model.sv */
`timescale 1ns/1ps
module lcl_ctrl_model (
  input  wire logic       clk,
  output logic            ck,
  output logic            cke,
  output logic            cs_n,
  output logic            ras_n,
  output logic            cas_n,
  output logic            we_n,
  output logic [1:0]      ba,
  output logic            a10
);
  initial
  begin
    ck = 1'b0;
    cke = 1'b1;
    {cs_n, ras_n, cas_n, we_n, ba, a10} = 7'h78;
  end

  // one ck pulse per command, ck stands low between frames
  // lo is the ck low time in clk, the command leads the ck rise by lo - 1 clk; lo of 4 gives an 80 ns ck
  // order and spacing are the caller's job
  task automatic issue(input logic [7:0] c, input int lo);
    @(posedge clk);
    {cke, cs_n, ras_n, cas_n, we_n, ba, a10} <= c;
    repeat (lo - 1) @(posedge clk);
    ck <= 1'b1;
    repeat (4) @(posedge clk);
    ck <= 1'b0;
    // held lines released: show the inverse, never a stale command
    {cs_n, ras_n, cas_n, we_n, ba, a10} <= ~c[6:0];
  endtask : issue
endmodule : lcl_ctrl_model

/* verification/lcl_properties.sv */
`timescale 1ns/1ps
module lcl_properties (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       ck,
  input wire logic       cke,
  input wire logic       cs_n,
  input wire logic       ras_n,
  input wire logic       cas_n,
  input wire logic       we_n,
  input wire logic [1:0] ba,
  input wire logic       a10,
  input wire logic       cmd_seen,
  input wire logic       cmd_accepted,
  input wire logic       cmd_ignored,
  input wire logic       cmd_illegal,
  input wire logic [2:0] cmd_code,
  input wire logic [2:0] dev_state,
  input wire logic [3:0] bank_idle,
  input wire logic       all_idle
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  sequence s_rise;
    $rose(ck);
  endsequence
  sequence s_pd_exit;
    dev_state == lcl_pkg::DEV_PD_EXIT;
  endsequence

  AST_SEEN_AFTER_RISE:
  assert property (s_rise |-> ##3 cmd_seen)
    else $error("ck rise not answered in time");
  AST_ONE_OUTCOME:
  assert property (cmd_seen |->
    $onehot({cmd_accepted, cmd_ignored, cmd_illegal}))
    else $error("not exactly one outcome");
  AST_NO_STRAY:
  assert property (!cmd_seen |->
    !(cmd_accepted || cmd_ignored || cmd_illegal))
    else $error("outcome without command");
  AST_ALL_IDLE:
  assert property ($fell(all_idle) |->
    cmd_accepted && cmd_code == lcl_pkg::CMD_ACT)
    else $error("bank opened without accepted activate");
  AST_REF_FROM_IDLE:
  assert property (($changed(dev_state) && dev_state inside
    {lcl_pkg::DEV_REFRESH, lcl_pkg::DEV_MODE_SET}) |-> $past(all_idle))
    else $error("refresh or mode set with open bank");
  AST_LOW_FROM_IDLE:
  assert property (($past(dev_state) == lcl_pkg::DEV_NORMAL &&
    dev_state inside {lcl_pkg::DEV_SELF_REFRESH, lcl_pkg::DEV_POWER_DOWN})
    |-> $past(all_idle))
    else $error("low power entered with open bank");
  AST_SR_KEPT:
  assert property ((cmd_illegal &&
    $past(dev_state) == lcl_pkg::DEV_SELF_REFRESH)
    |-> dev_state == lcl_pkg::DEV_SELF_REFRESH)
    else $error("illegal exit left self-refresh");
  AST_PD_NO_ILLEGAL:
  assert property ((cmd_seen && $past(dev_state) == lcl_pkg::DEV_POWER_DOWN)
    |-> !cmd_illegal && dev_state inside
    {lcl_pkg::DEV_POWER_DOWN, lcl_pkg::DEV_PD_EXIT})
    else $error("power-down command not ignored");
  AST_PD_EXIT_ONE:
  assert property (s_pd_exit |=> dev_state == lcl_pkg::DEV_NORMAL)
    else $error("power-down exit not one cycle");
endmodule : lcl_properties

/* verification/tb.sv */
`timescale 1ns/1ps
module tb;
  logic       clk, rstn, ck, cke, cs_n, ras_n, cas_n, we_n, a10;
  logic [1:0] ba;
  logic       cmd_seen, cmd_accepted, cmd_ignored, cmd_illegal, all_idle;
  logic [2:0] cmd_code, dev_state, got_res, got_code, got_dev;
  logic [3:0] bank_idle, got_idle;
  int         num_errors, n_compared, seen_n;

  localparam logic [2:0] ACC = 3'h4, IGN = 3'h2, ILL = 3'h1;

  lcl_command_legality dut (.clk, .rstn, .ck, .cke, .cs_n, .ras_n, .cas_n,
    .we_n, .ba, .a10, .cmd_seen, .cmd_accepted, .cmd_ignored, .cmd_illegal,
    .cmd_code, .dev_state, .bank_idle, .all_idle);
  lcl_ctrl_model ctl (.clk, .ck, .cke, .cs_n, .ras_n, .cas_n, .we_n, .ba,
    .a10);

  always #5 clk = ~clk;

  always @(posedge clk)
    if (cmd_seen === 1'b1)
    begin
      got_res <= {cmd_accepted, cmd_ignored, cmd_illegal};
      got_code <= cmd_code;
      got_dev <= dev_state;
      got_idle <= bank_idle;
      seen_n <= seen_n + 1;
    end

  task automatic end_of_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_of_test

  task automatic cmp(input string n, input logic [3:0] e, input logic [3:0] g);
    n_compared++;
    if (g !== e)
    begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : cmp

  // c = {cke, cs_n, ras_n, cas_n, we_n, ba, a10}
  task automatic run(input logic [7:0] c, input int lo, input logic [2:0] r,
                     input logic [2:0] d, input logic [3:0] i);
    int s;
    s = seen_n;
    ctl.issue(c, lo);
    // capture lands at the edge on which issue returns
    @(negedge clk);
    cmp("seen", 4'h1, 4'(seen_n - s));
    cmp("outcome", {1'b0, r}, {1'b0, got_res});
    cmp("code", {1'b0, c[6] ? 3'h0 : ~c[5:3]}, {1'b0, got_code});
    cmp("dev_state", {1'b0, d}, {1'b0, got_dev});
    cmp("bank_idle", i, got_idle);
  endtask : run

  task automatic t_reset();
    @(negedge clk);
    cmp("bank_idle", 4'hf, bank_idle);
    cmp("all_idle", 4'h1, {3'h0, all_idle});
    cmp("pulses", 4'h0, {1'b0, cmd_accepted, cmd_ignored, cmd_illegal});
  endtask : t_reset

  task automatic t_wake();
    run(8'hB8, 4, ACC, 3'h6, 4'hf);
    run(8'hC0, 4, IGN, 3'h0, 4'hf);
  endtask : t_wake

  task automatic t_banks();
    run(8'h9A, 4, ACC, 3'h0, 4'hd);
    run(8'hAC, 4, ILL, 3'h0, 4'hd);
    run(8'hA2, 4, ACC, 3'h0, 4'hd);
    run(8'h88, 4, ILL, 3'h0, 4'hd);
    run(8'h92, 4, ACC, 3'h0, 4'hd);
    run(8'h91, 4, IGN, 3'h0, 4'hf);
  endtask : t_banks

  task automatic t_refresh();
    run(8'h88, 4, ACC, 3'h1, 4'hf);
    // short ck low phase lands the next command inside the refresh
    run(8'h98, 2, ILL, 3'h1, 4'hf);
    run(8'h80, 4, ACC, 3'h2, 4'hf);
  endtask : t_refresh

  task automatic t_self_refresh();
    run(8'h08, 4, ACC, 3'h3, 4'hf);
    run(8'h38, 4, IGN, 3'h3, 4'hf);
    run(8'h98, 4, ILL, 3'h3, 4'hf);
    run(8'hB8, 4, ACC, 3'h4, 4'hf);
    run(8'h98, 4, ILL, 3'h4, 4'hf);
  endtask : t_self_refresh

  task automatic t_power_down();
    run(8'h38, 4, ACC, 3'h5, 4'hf);
    run(8'h18, 4, IGN, 3'h5, 4'hf);
    run(8'h80, 4, ACC, 3'h6, 4'hf);
    run(8'h9E, 4, ACC, 3'h0, 4'h7);
    // last on purpose: later enable history is left open
    run(8'h38, 4, ILL, 3'h0, 4'h7);
  endtask : t_power_down

  initial
  begin
    clk = 1'b0;
    rstn = 1'b0;
    num_errors = 0;
    n_compared = 0;
    seen_n = 0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_wake();
    t_banks();
    t_refresh();
    t_self_refresh();
    t_power_down();
    end_of_test();
  end

  initial
  begin
    #20000;
    num_errors++;
    $display("watchdog expired");
    end_of_test();
  end
endmodule : tb

bind lcl_command_legality lcl_properties chk (.clk, .rstn, .ck, .cke, .cs_n,
  .ras_n, .cas_n, .we_n, .ba, .a10, .cmd_seen, .cmd_accepted, .cmd_ignored,
  .cmd_illegal, .cmd_code, .dev_state, .bank_idle, .all_idle);
